// ==== rtl/sac_pkg.sv ====
// shared constants and types of the stack arithmetic command unit
package sac_pkg;
  // register word indexes on the avalon slave
  localparam logic [1:0] SAC_REG_DATA = 2'h0; // push on write, pop on read
  localparam logic [1:0] SAC_REG_CMD = 2'h1; // command byte, write only
  localparam logic [1:0] SAC_REG_STATUS = 2'h2; // status byte, read only
  localparam logic [1:0] SAC_REG_SRQ = 2'h3; // service request line
  // operation codes, bits 6..0 of the command byte
  localparam logic [6:0] SAC_OP_NOP = 7'h00;
  localparam logic [6:0] SAC_OP_ROOT = 7'h01;
  localparam logic [6:0] SAC_OP_CIRC = 7'h02;
  localparam logic [6:0] SAC_OP_POWER = 7'h0b;
  localparam logic [6:0] SAC_OP_PUSH_PI = 7'h1a;
  localparam logic [6:0] SAC_OP_ADD = 7'h6c;
  localparam logic [6:0] SAC_OP_SUB = 7'h6d;
  localparam logic [6:0] SAC_OP_MUL_LO = 7'h6e;
  localparam logic [6:0] SAC_OP_DIV = 7'h6f;
  localparam logic [6:0] SAC_OP_MUL_HI = 7'h76;
  localparam logic [6:0] SAC_OP_DUP = 7'h77;
  // execution times in clock cycles
  localparam int SAC_CNT_W = 14;
  localparam logic [13:0] SAC_CYC_NOP = 14'h0004;
  localparam logic [13:0] SAC_CYC_DUP = 14'h0010; // 16
  localparam logic [13:0] SAC_CYC_PUSH_PI = 14'h0010; // 16
  localparam logic [13:0] SAC_CYC_ADD = 14'h0010; // 16
  localparam logic [13:0] SAC_CYC_SUB = 14'h001e; // 30
  localparam logic [13:0] SAC_CYC_MUL_LO = 14'h0054; // 84
  localparam logic [13:0] SAC_CYC_MUL_HI = 14'h0050; // 80
  localparam logic [13:0] SAC_CYC_DIV = 14'h0054; // 84
  localparam logic [13:0] SAC_CYC_DIV0 = 14'h000e; // 14
  localparam logic [13:0] SAC_CYC_CIRC = 14'h0ed4; // 3796
  localparam logic [13:0] SAC_CYC_CIRC_FAST = 14'h001e; // 30
  localparam logic [13:0] SAC_CYC_ROOT = 14'h030e; // 782
  localparam logic [13:0] SAC_CYC_IGNORE = 14'h0001;
  // error field codes
  localparam logic [3:0] SAC_ERR_NONE = 4'h0;
  localparam logic [3:0] SAC_ERR_NEG_ARG = 4'h4; // 0100
  localparam logic [3:0] SAC_ERR_ARG_RANGE = 4'hc; // 1100
  localparam logic [3:0] SAC_ERR_OVF = 4'h8;
  localparam logic [3:0] SAC_ERR_DIV0 = 4'h2;
  // number formats
  localparam logic [15:0] SAC_MIN16 = 16'h8000;
  localparam logic [31:0] SAC_FLT_PI = 32'h40490fdb;
  localparam logic [7:0] SAC_EXP_BIAS = 8'h7f;
  localparam logic [7:0] SAC_EXP_SMALL = 8'h73; // 2^-12 and below
  localparam logic [7:0] SAC_LN2_Q8 = 8'hb1; // ln 2 in 1/256 units
  localparam logic [23:0] SAC_ARG_LIMIT = 24'h002000; // 32 in 1/256 units
  // status byte layout
  typedef struct packed {
    logic busy;
    logic sign;
    logic zero;
    logic [3:0] err;
    logic carry;
  } sac_status_type;
  typedef enum logic {SAC_ST_IDLE, SAC_ST_EXEC} sac_state_type;
endpackage

// ==== rtl/sac_stack_arith_cmd_unit.sv ====
// stack arithmetic command unit with avalon-mm register slave
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module sac_stack_arith_cmd_unit
  import sac_pkg::*;
#(
  parameter int DEPTH = 8, // sixteen-bit stack words
  parameter logic [13:0] POWER_CYCLES = 14'h2062 // 8290
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic service_request
);
  logic [15:0] stk_ff [DEPTH]; // word 0 is stack_top
  logic [15:0] nxt_stk [DEPTH];
  sac_status_type stat_ff; // status byte
  sac_status_type nxt_stat;
  sac_state_type state_ff; // idle or executing
  logic [SAC_CNT_W-1:0] cnt_ff; // cycles left in execution
  logic [SAC_CNT_W-1:0] nxt_cyc; // execution time of new command
  logic [7:0] cmd_ff; // command byte in flight
  logic wait_ff; // waitrequest register
  logic [31:0] rdata_ff; // read data register
  logic srq_ff; // service request line
  logic go; // request completes at this edge
  logic cmd_go; // command write completes
  logic allow; // slave may answer the pending request
  logic [6:0] op; // operation field of written command
  // 16-bit and 32-bit operand views
  logic [15:0] a16, b16;
  logic [31:0] a32, b32;
  logic [16:0] sum17, dif17;
  logic signed [31:0] prod;
  logic [15:0] quot;
  logic [8:0] root_exp; // halved unbiased exponent, rebiased
  logic [7:0] a_int; // saturated integer part of power exponent
  logic [7:0] lb_mag; // magnitude of integer log2 of base
  logic [23:0] arg_q8; // |A * ln B| estimate in 1/256 units

  assign readdata = rdata_ff;
  assign waitrequest = wait_ff;
  assign service_request = srq_ff;
  assign op = writedata[6:0];
  assign go = (read | write) & ~wait_ff;
  assign cmd_go = go & write & (address == SAC_REG_CMD);
  // status and service line answer even while a command runs
  assign allow = (address == SAC_REG_STATUS) ||
                 (address == SAC_REG_SRQ) || (state_ff == SAC_ST_IDLE);

  assign a16 = stk_ff[0];
  assign b16 = stk_ff[1];
  assign a32 = {stk_ff[0], stk_ff[1]};
  assign b32 = {stk_ff[2], stk_ff[3]};
  assign sum17 = {1'b0, b16} + {1'b0, a16};
  assign dif17 = {1'b0, b16} - {1'b0, a16};
  assign prod = $signed(a16) * $signed(b16);
  // zero divisor is steered away, so no division by zero is formed
  assign quot = 16'($signed(b16) / $signed((a16 == 16'h0000) ? 16'h0001 : a16));
  assign root_exp = 9'($signed({1'b0, a32[30:23]} - {1'b0, SAC_EXP_BIAS}) >>> 1)
                    + {1'b0, SAC_EXP_BIAS};
  // power range estimate: integer parts only, fraction of A is ignored
  always_comb begin
    logic signed [8:0] lb;
    logic signed [8:0] ae;
    lb = $signed({1'b0, b32[30:23]}) - $signed({1'b0, SAC_EXP_BIAS});
    ae = $signed({1'b0, a32[30:23]}) - $signed({1'b0, SAC_EXP_BIAS});
    lb_mag = lb[8] ? 8'(-lb) : lb[7:0];
    if (ae < 0) begin
      a_int = 8'h00;
    end else if (ae > 7) begin
      a_int = 8'hff;
    end else begin
      a_int = 8'({1'b1, a32[22:16]} >> (7 - ae));
    end
    arg_q8 = 24'(a_int * lb_mag) * 24'(SAC_LN2_Q8);
  end

  // next stack, status and execution time for the access at this edge
  always_comb begin
    nxt_stk = stk_ff;
    nxt_stat = stat_ff;
    nxt_cyc = SAC_CYC_IGNORE;
    if (go && write && address == SAC_REG_DATA) begin
      // push one word from the host
      for (int i = DEPTH - 1; i > 0; i--) begin
        nxt_stk[i] = stk_ff[i-1];
      end
      nxt_stk[0] = writedata[15:0];
    end else if (go && read && address == SAC_REG_DATA) begin
      // pop one word to the host, top rotates to the bottom
      for (int i = 0; i < DEPTH - 1; i++) begin
        nxt_stk[i] = stk_ff[i+1];
      end
      nxt_stk[DEPTH-1] = stk_ff[0];
    end else if (cmd_go) begin
      // binary 16-bit ops pop once; the old top lands at the bottom
      if (op inside {SAC_OP_ADD, SAC_OP_SUB, SAC_OP_MUL_LO, SAC_OP_MUL_HI,
                     SAC_OP_DIV}) begin
        for (int i = 1; i < DEPTH - 1; i++) begin
          nxt_stk[i] = stk_ff[i+1];
        end
        nxt_stk[DEPTH-1] = stk_ff[0];
        nxt_stat.err = SAC_ERR_NONE;
        nxt_stat.carry = 1'b0;
      end
      case (op)
        SAC_OP_NOP: begin
          nxt_stat = '0; // stack untouched, status cleared
          nxt_cyc = SAC_CYC_NOP;
        end
        SAC_OP_DUP: begin
          for (int i = DEPTH - 1; i > 0; i--) begin
            nxt_stk[i] = stk_ff[i-1]; // bottom word falls off
          end
          nxt_cyc = SAC_CYC_DUP;
        end
        SAC_OP_PUSH_PI: begin
          for (int i = DEPTH - 1; i > 1; i--) begin
            nxt_stk[i] = stk_ff[i-2]; // operand D falls off
          end
          {nxt_stk[0], nxt_stk[1]} = SAC_FLT_PI;
          nxt_cyc = SAC_CYC_PUSH_PI;
        end
        SAC_OP_ADD: begin
          nxt_stk[0] = sum17[15:0];
          nxt_stat.carry = sum17[16];
          if (a16[15] == b16[15] && sum17[15] != a16[15]) begin
            nxt_stat.err = SAC_ERR_OVF;
          end
          nxt_cyc = SAC_CYC_ADD;
        end
        SAC_OP_SUB: begin
          nxt_stk[0] = dif17[15:0];
          nxt_stat.carry = dif17[16]; // borrow
          if (a16 == SAC_MIN16 ||
              (a16[15] != b16[15] && dif17[15] != b16[15])) begin
            nxt_stat.err = SAC_ERR_OVF;
          end
          nxt_cyc = SAC_CYC_SUB;
        end
        SAC_OP_MUL_LO, SAC_OP_MUL_HI: begin
          if (a16 == SAC_MIN16 || b16 == SAC_MIN16) begin
            nxt_stk[0] = SAC_MIN16;
            nxt_stat.err = SAC_ERR_OVF;
          end else if (op == SAC_OP_MUL_LO) begin
            nxt_stk[0] = prod[15:0];
            if (prod[31:16] != 16'h0000) begin
              nxt_stat.err = SAC_ERR_OVF;
            end
          end else begin
            nxt_stk[0] = prod[31:16];
          end
          nxt_cyc = (op == SAC_OP_MUL_LO) ? SAC_CYC_MUL_LO : SAC_CYC_MUL_HI;
        end
        SAC_OP_DIV: begin
          if (a16 == 16'h0000) begin
            nxt_stk[0] = b16;
            nxt_stat.err = SAC_ERR_DIV0;
            nxt_cyc = SAC_CYC_DIV0;
          end else begin
            nxt_stk[0] = quot;
            nxt_cyc = SAC_CYC_DIV;
          end
        end
        SAC_OP_POWER: begin
          // pop one 32-bit operand; old A lands at the bottom
          for (int i = 2; i < DEPTH - 2; i++) begin
            nxt_stk[i] = stk_ff[i+2];
          end
          nxt_stk[DEPTH-2] = stk_ff[0];
          nxt_stk[DEPTH-1] = stk_ff[1];
          {nxt_stk[0], nxt_stk[1]} = b32;
          if (b32[31] || b32[30:23] == 8'h00) begin
            nxt_stat.err = SAC_ERR_NEG_ARG;
          end else if (arg_q8 > SAC_ARG_LIMIT) begin
            nxt_stat.err = SAC_ERR_ARG_RANGE;
          end else begin
            nxt_stat.err = SAC_ERR_NONE;
          end
          nxt_cyc = POWER_CYCLES;
        end
        SAC_OP_CIRC: begin
          // small angles return A; larger ones take the long path
          // exactly 2^-12 is still small; any mantissa bit makes it larger
          nxt_cyc = (a32[30:23] < SAC_EXP_SMALL ||
                     (a32[30:23] == SAC_EXP_SMALL && a32[22:0] == 23'h0))
                    ? SAC_CYC_CIRC_FAST : SAC_CYC_CIRC;
        end
        SAC_OP_ROOT: begin
          if (a32[31] && a32[30:0] != 31'h0) begin
            nxt_stat.err = SAC_ERR_NEG_ARG;
          end else begin
            nxt_stat.err = SAC_ERR_NONE;
            if (a32[30:23] != 8'h00) begin
              {nxt_stk[0], nxt_stk[1]} = {1'b0, root_exp[7:0], a32[22:0]};
            end
          end
          nxt_cyc = SAC_CYC_ROOT;
        end
        default: begin
          nxt_cyc = SAC_CYC_IGNORE; // unknown code: stack kept, busy for one cycle
        end
      endcase
      // sign and zero follow the new top operand
      if (op != SAC_OP_NOP) begin
        nxt_stat.sign = nxt_stk[0][15];
        nxt_stat.zero = (op inside {SAC_OP_ADD, SAC_OP_SUB, SAC_OP_MUL_LO,
                         SAC_OP_MUL_HI, SAC_OP_DIV, SAC_OP_DUP})
                        ? (nxt_stk[0] == 16'h0000)
                        : ({nxt_stk[0], nxt_stk[1]} == 32'h0);
      end
    end
  end

  // stack storage
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        stk_ff[i] <= 16'h0000;
      end
    end else begin
      stk_ff <= nxt_stk;
    end
  end

  // status byte; busy marks a running command
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      stat_ff <= '0;
    end else if (cmd_go) begin
      stat_ff <= nxt_stat;
      stat_ff.busy <= 1'b1;
    end else if (state_ff == SAC_ST_EXEC && cnt_ff == '0) begin
      stat_ff.busy <= 1'b0;
    end
  end

  // execution sequencer: counts the documented time of each command
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_ff <= SAC_ST_IDLE;
      cnt_ff <= '0;
      cmd_ff <= 8'h00;
    end else begin
      case (state_ff)
        SAC_ST_IDLE: begin
          if (cmd_go) begin
            state_ff <= SAC_ST_EXEC;
            cnt_ff <= nxt_cyc - 1'b1;
            cmd_ff <= writedata[7:0];
          end
        end
        SAC_ST_EXEC: begin
          if (cnt_ff == '0) begin
            state_ff <= SAC_ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        default: begin
          state_ff <= SAC_ST_IDLE;
        end
      endcase
    end
  end

  // service request line takes the flag of each finished command
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      srq_ff <= 1'b0;
    end else if (state_ff == SAC_ST_EXEC && cnt_ff == '0) begin
      srq_ff <= cmd_ff[7];
    end
  end

  // avalon handshake: one wait cycle once allowed, then a single low cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wait_ff <= 1'b1;
    end else if (!wait_ff) begin
      wait_ff <= 1'b1;
    end else if ((read || write) && allow) begin
      wait_ff <= 1'b0;
    end
  end

  // read data is captured when waitrequest is dropped
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata_ff <= 32'h0;
    end else if (wait_ff && read && allow) begin
      case (address)
        SAC_REG_DATA: rdata_ff <= {16'h0000, stk_ff[0]};
        SAC_REG_STATUS: rdata_ff <= {24'h000000, stat_ff};
        SAC_REG_SRQ: rdata_ff <= {31'h0, srq_ff};
        default: rdata_ff <= 32'h0;
      endcase
    end
  end

  // checks
  chk_dup_copy: assert property (@(posedge sys_clk) disable iff (!rstn)
    cmd_go && op == SAC_OP_DUP |=> stk_ff[1] == $past(stk_ff[0])
    && stk_ff[0] == $past(stk_ff[0]))
    else $error("duplicate top wrong");
  chk_pi_push: assert property (@(posedge sys_clk) disable iff (!rstn)
    cmd_go && op == SAC_OP_PUSH_PI |=> {stk_ff[0], stk_ff[1]} == SAC_FLT_PI
    && stk_ff[2] == $past(stk_ff[0]))
    else $error("pi push wrong");
  chk_add_time: assert property (@(posedge sys_clk) disable iff (!rstn)
    cmd_go && op == SAC_OP_ADD |-> ##16 stat_ff.busy ##1 !stat_ff.busy)
    else $error("add time wrong");
  chk_div_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    cmd_go && op == SAC_OP_DIV && a16 == 16'h0000 |=>
    stk_ff[0] == $past(b16) && stat_ff.err == SAC_ERR_DIV0 ##14 !stat_ff.busy)
    else $error("zero divide wrong");
  chk_mul_min: assert property (@(posedge sys_clk) disable iff (!rstn)
    cmd_go && (op == SAC_OP_MUL_LO || op == SAC_OP_MUL_HI) &&
    (a16 == SAC_MIN16 || b16 == SAC_MIN16) |=>
    stk_ff[0] == SAC_MIN16 && stat_ff.err == SAC_ERR_OVF)
    else $error("most negative product wrong");
  chk_sub_borrow: assert property (@(posedge sys_clk) disable iff (!rstn)
    cmd_go && op == SAC_OP_SUB |=> stat_ff.carry == ($past(b16) < $past(a16)))
    else $error("borrow wrong");
  chk_root_neg: assert property (@(posedge sys_clk) disable iff (!rstn)
    cmd_go && op == SAC_OP_ROOT && a32[31] && a32[30:0] != 31'h0 |=>
    stat_ff.err == SAC_ERR_NEG_ARG)
    else $error("negative root not flagged");
  chk_srq_line: assert property (@(posedge sys_clk) disable iff (!rstn)
    cmd_go && op == SAC_OP_NOP |-> ##5 srq_ff == $past(writedata[7], 5))
    else $error("service line wrong");
  cov_div_zero: cover property (@(posedge sys_clk) disable iff (!rstn)
    cmd_go && op == SAC_OP_DIV && a16 == 16'h0000);
  cov_add_ovf: cover property (@(posedge sys_clk) disable iff (!rstn)
    cmd_go && op == SAC_OP_ADD ##1 stat_ff.err == SAC_ERR_OVF);
  cov_circ_fast: cover property (@(posedge sys_clk) disable iff (!rstn)
    cmd_go && op == SAC_OP_CIRC && a32[30:23] < SAC_EXP_SMALL);
endmodule
`default_nettype wire

// ==== verification/sac_host_model.sv ====
// host side model: avalon-mm master that issues data words and commands
`timescale 1ns/1ps
`default_nettype none
module sac_host_model (
  input wire logic sys_clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic [1:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata
);
  // idle bus from time zero
  initial begin
    address = 2'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
  end
  // one access, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [1:0] adr,
                      input logic [31:0] dat, output logic [31:0] q);
    @(posedge sys_clk);
    address <= adr;
    writedata <= dat;
    write <= wr;
    read <= ~wr;
    // waits as long as the slave stalls; the bench watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    // released data is scrambled so nothing leans on a stale word
    writedata <= ~dat;
  endtask
endmodule
`default_nettype wire

// ==== verification/sac_stack_arith_cmd_unit_bench.sv ====
// self-checking bench of the stack arithmetic command unit
`timescale 1ns/1ps
`default_nettype none
module sac_stack_arith_cmd_unit_bench;
  import sac_pkg::*;
  // one table row: operands, expected top word, status and time
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] b;
    logic [15:0] a;
    logic [15:0] r;
    logic [7:0] st;
    logic [13:0] cyc;
  } sac_row_type;
  logic sys_clk;
  logic rstn;
  logic [1:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic service_request;
  int error_cnt;
  int num_checks;
  sac_row_type rows [11];
  // short power time keeps the run brief
  sac_stack_arith_cmd_unit #(.DEPTH(8), .POWER_CYCLES(14'h0014))
      sac_stack_arith_cmd_unit_i (
    .sys_clk(sys_clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .service_request(service_request));
  sac_host_model sac_host_model_i (
    .sys_clk(sys_clk), .waitrequest(waitrequest), .readdata(readdata),
    .address(address), .read(read), .write(write), .writedata(writedata));
  // 125 mhz clock
  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;
  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // compare and count
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic push(input logic [15:0] w);
    logic [31:0] q;
    sac_host_model_i.xfer(1'b1, SAC_REG_DATA, {16'h0, w}, q);
  endtask
  // 32-bit operand: lower word first, upper word last
  task automatic push32(input logic [15:0] up);
    push(16'h0000);
    push(up);
  endtask
  task automatic rd(input logic [1:0] adr, output logic [31:0] q);
    sac_host_model_i.xfer(1'b0, adr, 32'h0, q);
  endtask
  // clear the line with a no-op, then time a flagged command
  task automatic run_cmd(input logic [7:0] cmd, input logic [13:0] cyc);
    logic [31:0] q;
    int n;
    sac_host_model_i.xfer(1'b1, SAC_REG_CMD, 32'h0, q);
    sac_host_model_i.xfer(1'b1, SAC_REG_CMD, {24'h0, cmd}, q);
    check("line cleared", 32'h0, {31'h0, service_request});
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (service_request !== 1'b1 && n < 6000);
    check("cycles", {18'h0, cyc} + 32'h1, 32'(n));
  endtask
  // watchdog, well past the longest expected run
  initial begin
    repeat (30000) @(posedge sys_clk);
    error_cnt++;
    $display("[FAIL] watchdog expected finish seen timeout");
    end_of_test();
  end
  // main sequence
  initial begin
    logic [31:0] q;
    rstn = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    rows = '{
      '{8'hec, 16'h7fff, 16'h0001, 16'h8000, 8'h50, SAC_CYC_ADD},
      '{8'hec, 16'hffff, 16'h0001, 16'h0000, 8'h21, SAC_CYC_ADD},
      '{8'hed, 16'h0000, 16'h0001, 16'hffff, 8'h41, SAC_CYC_SUB},
      '{8'hed, 16'h0000, 16'h8000, 16'h8000, 8'h51, SAC_CYC_SUB},
      '{8'hee, 16'h0100, 16'h0100, 16'h0000, 8'h30, SAC_CYC_MUL_LO},
      '{8'hee, 16'h8000, 16'h0003, 16'h8000, 8'h50, SAC_CYC_MUL_LO},
      '{8'hf6, 16'h4000, 16'h0004, 16'h0001, 8'h00, SAC_CYC_MUL_HI},
      '{8'hf6, 16'h0002, 16'h8000, 16'h8000, 8'h50, SAC_CYC_MUL_HI},
      '{8'hef, 16'h0007, 16'h0002, 16'h0003, 8'h00, SAC_CYC_DIV},
      '{8'hef, 16'h1234, 16'h0000, 16'h1234, 8'h04, SAC_CYC_DIV0},
      '{8'hf7, 16'h0005, 16'h0009, 16'h0009, 8'h00, SAC_CYC_DUP}
    };
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    check("line after reset", 32'h0, {31'h0, service_request});
    rd(SAC_REG_STATUS, q);
    check("status after reset", 32'h0, q);
    rd(SAC_REG_CMD, q);
    check("command read", 32'h0, q);
    // table of 16-bit commands
    foreach (rows[i]) begin
      push(rows[i].b);
      push(rows[i].a);
      run_cmd(rows[i].cmd, rows[i].cyc);
      rd(SAC_REG_DATA, q);
      check("result", {16'h0, rows[i].r}, q);
      rd(SAC_REG_STATUS, q);
      check("status", {24'h0, rows[i].st}, q);
    end
    // constant push, upper word on top
    run_cmd(8'h9a, SAC_CYC_PUSH_PI);
    rd(SAC_REG_DATA, q);
    check("pi upper", {16'h0, SAC_FLT_PI[31:16]}, q);
    rd(SAC_REG_DATA, q);
    check("pi lower", {16'h0, SAC_FLT_PI[15:0]}, q);
    // duplicate with the flag clear: line falls, copy sits twice
    push(16'h0042);
    sac_host_model_i.xfer(1'b1, SAC_REG_CMD, 32'h77, q);
    rd(SAC_REG_DATA, q);
    check("dup top", 32'h0042, q);
    rd(SAC_REG_DATA, q);
    check("dup copy", 32'h0042, q);
    check("line after 77", 32'h0, {31'h0, service_request});
    // negative root operand
    push32(16'hc080);
    run_cmd(8'h81, SAC_CYC_ROOT);
    rd(SAC_REG_STATUS, q);
    check("root error", 32'h08, q & 32'h1e);
    // power with a negative base, then with an out-of-range product
    push32(16'hbf80);
    push32(16'h3f80);
    run_cmd(8'h8b, 14'h0014);
    rd(SAC_REG_STATUS, q);
    check("power base", 32'h08, q & 32'h1e);
    push32(16'h7180);
    push32(16'h3f80);
    run_cmd(8'h8b, 14'h0014);
    rd(SAC_REG_STATUS, q);
    check("power range", 32'h18, q & 32'h1e);
    // circular function, long and short paths, second operand kept
    push(16'h0077);
    push32(16'h3f80);
    run_cmd(8'h82, SAC_CYC_CIRC);
    rd(SAC_REG_STATUS, q);
    check("circular flags", 32'h0, q & 32'h1f);
    push32(16'h3900);
    run_cmd(8'h82, SAC_CYC_CIRC_FAST);
    repeat (2) rd(SAC_REG_DATA, q);
    rd(SAC_REG_DATA, q);
    check("circular keeps second", 32'h3f80, q);
    // just above the small-angle limit the long path is taken
    push32(16'h39c0);
    run_cmd(8'h82, SAC_CYC_CIRC);
    // no-op raising the line, then an undecoded code
    run_cmd(8'h80, SAC_CYC_NOP);
    run_cmd(8'hff, SAC_CYC_IGNORE);
    // reset in mid-run: line, status and stack return to zero
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    check("line after second reset", 32'h0, {31'h0, service_request});
    rd(SAC_REG_STATUS, q);
    check("status after second reset", 32'h0, q);
    rd(SAC_REG_DATA, q);
    check("stack after second reset", 32'h0, q);
    end_of_test();
  end
endmodule
`default_nettype wire
